// ==== common/bie_pkg.sv ====
// constants, opcodes and types for the branch/increment execute block
package bie_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 13;
  localparam int INSTR_W = 14;
  localparam int LIT_W = 11;
  // instruction fields
  localparam int OP3_HI = 13;
  localparam int OP3_LO = 11;
  localparam int OP6_HI = 13;
  localparam int OP6_LO = 8;
  localparam int DEST_BIT = 7;
  localparam int FADDR_HI = 6;
  localparam int LIT_HI = 10;
  localparam int LATCH_HI = 4;
  localparam int LATCH_LO = 3;
  // opcodes
  // jump is 3'b101 in bits 13:11; 3'b100 is a different branch, not ours
  localparam logic [2:0] OP_JUMP = 3'h5;
  localparam logic [5:0] OP_INC = 6'h0a;
  localparam logic [5:0] OP_INCSZ = 6'h0f;
  localparam logic [DATA_W-1:0] ONE_DATA = 8'h01;
  localparam logic [DATA_W-1:0] ZERO_DATA = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
  localparam logic [FADDR_W-1:0] FADDR_ZERO = 7'h00;
  localparam logic [INSTR_W-1:0] INSTR_ZERO = 14'h0000;
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;
  typedef enum logic [1:0] {
    BIE_Q1 = 2'b00,
    BIE_Q2 = 2'b01,
    BIE_Q3 = 2'b10,
    BIE_Q4 = 2'b11
  } bie_phase_e;
endpackage

// ==== rtl/bie_core.sv ====
// execute stage for jump, increment and increment-skip-if-zero
// ============================================================
// Functional notes
// - increments add one to the addressed register; the sum is the result.
// - destination bit 0 writes result to accumulator, register untouched.
// - destination bit 1 writes result back to the source register.
// - increment-skip with zero result turns the next instruction into a nop.
// - increment-skip takes one cycle, or two when the skip is taken.
// - quarters: decode, read register, compute, write destination.
`timescale 1ns/1ps
`default_nettype none
module bie_core
  import bie_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst, // async reset, active high
  input wire logic [INSTR_W-1:0] instr, // fetched instruction word
  input wire logic [DATA_W-1:0] program_counter_high_latch, // high pc latch
  input wire logic [DATA_W-1:0] rd_data, // data register read value
  output logic [FADDR_W-1:0] rd_addr, // data register read address
  output logic rd_en, // read strobe in the second quarter
  output logic [FADDR_W-1:0] wr_addr, // data register write address
  output logic [DATA_W-1:0] wr_data, // data register write value
  output logic wr_en, // register write strobe in the fourth quarter
  output logic [DATA_W-1:0] w_acc, // working accumulator
  output logic [PC_W-1:0] pc, // program counter
  output logic [1:0] phase, // current quarter
  output logic nop_cycle, // this cycle is an empty one
  output logic zero_flag_wr, // zero flag update strobe, plain increment
  output logic zero_flag_val // zero flag value on update
);
  // ============================================================
  // decode helpers
  function automatic logic is_jump(input logic [INSTR_W-1:0] i);
    return i[OP3_HI:OP3_LO] == OP_JUMP;
  endfunction
  function automatic logic is_inc(input logic [INSTR_W-1:0] i);
    return i[OP6_HI:OP6_LO] == OP_INC;
  endfunction
  function automatic logic is_incsz(input logic [INSTR_W-1:0] i);
    return i[OP6_HI:OP6_LO] == OP_INCSZ;
  endfunction

  bie_phase_e phase_r;
  logic [INSTR_W-1:0] ir_r;
  logic [DATA_W-1:0] opnd_r;
  logic [DATA_W-1:0] sum_r;
  logic nop_r;
  logic flush_r;

  // ============================================================
  // quarter sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r <= BIE_Q1;
    end else begin
      unique case (phase_r)
        BIE_Q1: phase_r <= BIE_Q2;
        BIE_Q2: phase_r <= BIE_Q3;
        BIE_Q3: phase_r <= BIE_Q4;
        BIE_Q4: phase_r <= BIE_Q1;
      endcase
    end
  end

  // ============================================================
  // decode in Q1; an empty cycle still latches the instruction and marks it with nop_r
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ir_r <= INSTR_ZERO;
      nop_r <= 1'b0;
    end else if (phase_r == BIE_Q1) begin
      ir_r <= instr;
      nop_r <= flush_r;
    end
  end

  // ============================================================
  // read in Q2, process in Q3
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opnd_r <= ZERO_DATA;
      sum_r <= ZERO_DATA;
    end else begin
      if (phase_r == BIE_Q2) begin
        opnd_r <= rd_data;
      end
      if (phase_r == BIE_Q3) begin
        sum_r <= opnd_r + ONE_DATA;
      end
    end
  end

  logic live_inc;
  assign live_inc = !nop_r && (is_inc(ir_r) || is_incsz(ir_r));

  // read strobe and address, registered one quarter ahead
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_en <= 1'b0;
      rd_addr <= FADDR_ZERO;
    end else begin
      rd_en <= (phase_r == BIE_Q1) && !flush_r &&
               (is_inc(instr) || is_incsz(instr));
      if (phase_r == BIE_Q1) begin
        rd_addr <= instr[FADDR_HI:0];
      end
    end
  end

  // ============================================================
  // write-back in Q4; sum ready after Q3 edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_en <= 1'b0;
      wr_addr <= FADDR_ZERO;
      wr_data <= ZERO_DATA;
    end else begin
      wr_en <= (phase_r == BIE_Q3) && live_inc &&
               ir_r[DEST_BIT];
      wr_addr <= ir_r[FADDR_HI:0];
      wr_data <= opnd_r + ONE_DATA;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_acc <= W_RESET;
    end else if (phase_r == BIE_Q4 && live_inc && !ir_r[DEST_BIT]) begin
      w_acc <= sum_r;
    end
  end

  // zero flag: plain increment only; skip form and jump leave it alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zero_flag_wr <= 1'b0;
      zero_flag_val <= 1'b0;
    end else begin
      zero_flag_wr <= (phase_r == BIE_Q3) && !nop_r && is_inc(ir_r);
      zero_flag_val <= (opnd_r + ONE_DATA) == ZERO_DATA;
    end
  end

  // ============================================================
  // program counter and flush of the following cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc <= PC_RESET;
      flush_r <= 1'b0;
    end else if (phase_r == BIE_Q4) begin
      if (!nop_r && is_jump(ir_r)) begin
        pc <= {program_counter_high_latch[LATCH_HI:LATCH_LO],
               ir_r[LIT_HI:0]};
        flush_r <= 1'b1;
      end else begin
        pc <= pc + PC_ONE;
        flush_r <= !nop_r && is_incsz(ir_r) &&
                   (sum_r == ZERO_DATA);
      end
    end
  end

  assign phase = phase_r;
  assign nop_cycle = nop_r;

  // ============================================================
  // checks
  // nop_r moves on the decode edge, so an empty cycle shows from q2 to
  // the following q1: the checks wait one quarter past the q1 boundary
  sequence s_incsz_zero;
    phase_r == BIE_Q4 && !nop_r && is_incsz(ir_r) && sum_r == ZERO_DATA;
  endsequence
  sequence s_empty_cycle;
    nop_r [*4];
  endsequence

  AST_SUM_WRITE: assert property (@(posedge clk) disable iff (rst)
    wr_en |-> wr_data == $past(opnd_r) + ONE_DATA)
    else $error("write data is not operand plus one");
  AST_ACC_DEST: assert property (@(posedge clk) disable iff (rst)
    (phase_r == BIE_Q4 && live_inc && !ir_r[DEST_BIT])
      |-> !wr_en ##1 w_acc == $past(sum_r))
    else $error("accumulator result wrong or register written");
  AST_REG_DEST: assert property (@(posedge clk) disable iff (rst)
    (phase_r == BIE_Q3 && live_inc && ir_r[DEST_BIT])
      |=> wr_en && wr_addr == $past(ir_r[FADDR_HI:0]))
    else $error("register destination not written");
  AST_SKIP_NOP: assert property (@(posedge clk) disable iff (rst)
    s_incsz_zero |=> ##1 s_empty_cycle)
    else $error("skip did not insert an empty cycle");
  AST_NO_SKIP: assert property (@(posedge clk) disable iff (rst)
    (phase_r == BIE_Q4 && !nop_r && is_incsz(ir_r) && sum_r != ZERO_DATA)
      |=> ##1 !nop_r)
    else $error("nonzero result caused a skip");
  AST_WRITE_Q4: assert property (@(posedge clk) disable iff (rst)
    wr_en |-> phase_r == BIE_Q4 && $past(phase_r) == BIE_Q3)
    else $error("register write outside fourth quarter");
  AST_READ_Q2: assert property (@(posedge clk) disable iff (rst)
    rd_en |-> phase_r == BIE_Q2)
    else $error("register read outside second quarter");
  AST_JUMP: assert property (@(posedge clk) disable iff (rst)
    (phase_r == BIE_Q4 && !nop_r && is_jump(ir_r))
      |=> pc == {$past(program_counter_high_latch[LATCH_HI:LATCH_LO]),
                 $past(ir_r[LIT_HI:0])} ##1 s_empty_cycle)
    else $error("jump target or empty cycle wrong");
endmodule // bie_core
`default_nettype wire

// ==== verif/branch_increment_execute_tb.sv ====
// self-checking bench for the branch/increment execute block
`timescale 1ns/1ps
`default_nettype none
module branch_increment_execute_tb;
  import bie_pkg::*;
  typedef struct {
    logic [INSTR_W-1:0] ins;
    logic [DATA_W-1:0] f;
    logic [DATA_W-1:0] res;
  } bie_row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [INSTR_W-1:0] instr = INSTR_ZERO;
  logic [DATA_W-1:0] latch = 8'he8;
  logic [DATA_W-1:0] rd_data = ZERO_DATA;
  logic [FADDR_W-1:0] rd_addr, wr_addr;
  logic [DATA_W-1:0] wr_data, w_acc;
  logic [PC_W-1:0] pc, pc_m;
  logic [1:0] phase;
  logic rd_en, wr_en, nop_cycle, zero_flag_wr, zero_flag_val;
  logic [DATA_W-1:0] w_m;
  logic nop_m;
  int fail_count = 0;
  int total_checks = 0;
  // rows 5, 7 and 9 follow a skip or jump, so they must be swallowed
  bie_row_s rows[10] = '{'{14'h0a85, 8'h12, 8'h13}, '{14'h0a10, 8'hff, 8'h00},
    '{14'h0f85, 8'h7f, 8'h80}, '{14'h0f20, 8'hff, 8'h00},
    '{14'h0a85, 8'h40, 8'h41}, '{14'h2ba5, 8'h00, 8'h00},
    '{14'h0a01, 8'h01, 8'h02}, '{14'h0fff, 8'hff, 8'h00},
    '{14'h2800, 8'h00, 8'h00}, '{14'h0400, 8'h00, 8'h00}};
  always #10 clk = ~clk;
  bie_core i_dut (.clk(clk), .rst(rst), .instr(instr),
    .program_counter_high_latch(latch), .rd_data(rd_data),
    .rd_addr(rd_addr), .rd_en(rd_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_en(wr_en), .w_acc(w_acc), .pc(pc), .phase(phase),
    .nop_cycle(nop_cycle), .zero_flag_wr(zero_flag_wr),
    .zero_flag_val(zero_flag_val));
  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic results;
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one full instruction cycle; the bench model tracks pc, w and skips
  task automatic exec(input bie_row_s r);
    logic live, inc, jmp, d;
    logic [5:0] op;
    int n;
    n = 0;
    while (phase !== BIE_Q1 && n < 8) begin
      step();
      n++;
    end
    if (n == 8) begin
      fail_count++;
      $display("Error %0t: no first quarter", $time);
      results();
    end
    op = r.ins[OP6_HI:OP6_LO];
    live = !nop_m;
    d = r.ins[DEST_BIT];
    inc = live && (op == OP_INC || op == OP_INCSZ);
    jmp = live && r.ins[OP3_HI:OP3_LO] == OP_JUMP;
    instr = r.ins;
    rd_data = r.f;
    step();
    // the empty-cycle flag only turns over at the end of the first quarter
    chk(nop_cycle, !live, "nop");
    chk(rd_en, inc, "rd_en");
    if (inc) chk(rd_addr, r.ins[FADDR_HI:0], "rd_addr");
    step();
    step();
    chk(wr_en, inc && d, "wr_en");
    if (inc && d) chk({wr_addr, wr_data}, {r.ins[6:0], r.res}, "wr");
    chk(zero_flag_wr, live && op == OP_INC, "zf_wr");
    if (live && op == OP_INC) chk(zero_flag_val, r.res == 0, "zf");
    step();
    pc_m = jmp ? {latch[LATCH_HI:LATCH_LO], r.ins[LIT_HI:0]} : pc_m + PC_ONE;
    if (inc && !d) w_m = r.res;
    nop_m = jmp || (inc && op == OP_INCSZ && r.res == ZERO_DATA);
    chk(pc, pc_m, "pc");
    chk(w_acc, w_m, "w_acc");
    $display("test done: instr %h", r.ins);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    pc_m = PC_RESET;
    w_m = W_RESET;
    nop_m = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk({phase, pc, wr_en}, 16'h0000, "reset");
    rst = 1'b0;
    foreach (rows[i]) exec(rows[i]);
    // reset in the third quarter must kill the pending write
    instr = 14'h0a85;
    step();
    step();
    rst = 1'b1;
    #2;
    chk({phase, pc, wr_en}, 16'h0000, "mid reset");
    step();
    chk({phase, pc, wr_en}, 16'h0000, "reset hold");
    chk(w_acc, W_RESET, "reset w_acc");
    rst = 1'b0;
    pc_m = PC_RESET;
    w_m = W_RESET;
    nop_m = 1'b0;
    $display("test done: mid-run reset");
    exec('{14'h0f01, 8'h7f, 8'h80});
    results();
  end
endmodule // branch_increment_execute_tb
`default_nettype wire
